// ===== dv/apb_host_model.sv
// APB host model standing in for the fieldbus master
`timescale 1ns/100ps
module apb_host_model (
  input wire ref_clk,
  input wire pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic hung
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // Setup then access; released lines show inverted data, never the old value
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!pready && n < 64);
    hung <= !pready;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // apb_host_model

// ===== dv/mode_ctrl_monitor.sv
// Port checker bound to the torque and homing mode controller
`timescale 1ns/100ps
`include "torque_homing_defs.vh"
module mode_ctrl_monitor (
  input wire ref_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire pready,
  input wire pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire closed_loop_on,
  input wire torque_active,
  input wire speed_cap_on,
  input wire position_zero_load,
  input wire [15:0] torque_demand,
  input wire [31:0] speed_command,
  input wire [31:0] position_zero
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable && pready;
  // Limit shadows start wide open so no bound is judged before software sets it; mode, submode and offset shadows start at zero
  reg [31:0] mode_q = 32'h0;
  reg [31:0] slope_q = 32'hFFFFFFFF;
  reg [31:0] mt_q = 32'hFFFFFFFF;
  reg [31:0] mc_q = 32'hFFFFFFFF;
  reg [31:0] mmc_q = 32'hFFFFFFFF;
  reg [31:0] sub_q = 32'h0;
  reg [31:0] hoff_q = 32'h0;
  reg [31:0] spd_q = 32'hFFFFFFFF;
  reg [15:0] prev_dem;
  reg [17:0] since_chg;
  wire [31:0] step = (slope_q < 32'h3E8) ? 32'h1 : slope_q / 32'h3E8;
  wire [15:0] delta = (torque_demand >= prev_dem) ? torque_demand - prev_dem : prev_dem - torque_demand;
  // Track accepted writes to the mode, submode, home offset and limit registers
  always @(posedge ref_clk) begin
    if (acc && pwrite && !pslverr) begin
      case (paddr)
        `REG_MODE: mode_q <= pwdata;
        `REG_TORQUE_SLOPE: slope_q <= {16'h0, pwdata[15:0]};
        `REG_MAX_TORQUE: mt_q <= {16'h0, pwdata[15:0]};
        `REG_MAX_CURRENT: mc_q <= {16'h0, pwdata[15:0]};
        `REG_MOTOR_MAX_CURRENT: mmc_q <= {16'h0, pwdata[15:0]};
        `REG_SUBMODE: sub_q <= pwdata;
        `REG_HOME_OFFSET: hoff_q <= pwdata;
        `REG_MAX_SPEED: spd_q <= pwdata;
        default: ;
      endcase
    end
  end
  // Cycles since the demand last moved, saturating so a long idle stays legal
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_dem <= 16'h0;
      since_chg <= 18'h3FFFF;
    end else begin
      prev_dem <= torque_demand;
      if (torque_demand != prev_dem) begin
        since_chg <= 18'h0;
      end else if (since_chg != 18'h3FFFF) begin
        since_chg <= since_chg + 18'h1;
      end
    end
  end
  chk_bad_addr_err: assert property (acc |-> pslverr == (paddr > 12'h054 || paddr[1:0] != 2'h0))
    else $error("pslverr does not match the address decode");
  chk_slope_limit: assert property ({16'h0, delta} <= step)
    else $error("torque demand stepped faster than the slope");
  chk_demand_cap: assert property ({16'h0, torque_demand} <= mt_q && {16'h0, torque_demand} <= mc_q
    && {16'h0, torque_demand} <= mmc_q && torque_demand <= 16'h3E8) else $error("torque demand above a limit");
  chk_tick_spacing: assert property (torque_demand != prev_dem |-> since_chg >= `CYCLE_COUNT - 1)
    else $error("torque demand moved between control ticks");
  chk_load_pulse: assert property (position_zero_load |=> !position_zero_load && position_zero == hoff_q)
    else $error("zero load pulse or offset wrong");
  chk_submode_cap: assert property ($changed(speed_cap_on) |-> speed_cap_on == !sub_q[5])
    else $error("speed cap disagrees with submode");
  chk_active_cause: assert property ($rose(torque_active) |-> closed_loop_on && mode_q[7:0] == `MODE_TORQUE)
    else $error("torque mode went live without its cause");
  chk_speed_bound: assert property (speed_command <= spd_q)
    else $error("speed command above maximum speed");
  cover property (acc && pslverr);
  cover property (position_zero_load);
  cover property ($rose(torque_active));
  cover property ($fell(speed_cap_on));
endmodule // mode_ctrl_monitor
bind torque_and_homing_mode_ctrl mode_ctrl_monitor mon_u (.*);

// ===== dv/torque_and_homing_mode_ctrl_tb_top.sv
// Self-checking bench for the torque and homing mode controller
`timescale 1ns/100ps
`include "torque_homing_defs.vh"
module torque_and_homing_mode_ctrl_tb_top;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, hung, block_homing;
  logic closed_loop_on, speed_zero, switch_found, index_found, homing_fault;
  logic torque_active, speed_cap_on, position_zero_load;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, speed_command, accel_command, position_zero, hoff;
  logic [15:0] actual_torque, motor_current, torque_demand;
  logic [65:0] expq[$];
  logic [65:0] ent;
  int n_errors = 0;
  int total_checks = 0;
  int n;
  torque_and_homing_mode_ctrl dut_u (.*);
  apb_host_model host_u (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d);
  endtask
  // Read notes {mask, expected} for the watcher; bit 32 is pslverr
  task automatic rd(input logic [11:0] a, input logic [32:0] m, input logic [32:0] e);
    expq.push_back({m, e & m});
    host_u.xfer(1'b0, a, 32'h0);
  endtask
  // Status only moves on the control tick, so whole ticks are waited
  task automatic ticks(input int k);
    repeat (k * `CYCLE_COUNT) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Watcher pairs each completed read with the oldest note
  always @(posedge ref_clk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      ent = expq.pop_front();
      check({pslverr, prdata} & ent[65:33], ent[32:0]);
    end
    if (hung) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    rst_b = 1'b0;
    closed_loop_on = 1'b0;
    actual_torque = 16'h0;
    motor_current = 16'h0;
    block_homing = 1'b0;
    speed_zero = 1'b0;
    switch_found = 1'b0;
    index_found = 1'b0;
    homing_fault = 1'b0;
    void'($urandom(32'h7FD9));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    // Unmapped and misaligned reads are refused
    rd(12'h058, 33'h1FFFFFFFF, 33'h100000000);
    rd(12'h006, 33'h1FFFFFFFF, 33'h100000000);
    hoff = $urandom();
    wr(`REG_HOME_OFFSET, hoff);
    rd(`REG_HOME_OFFSET, 33'h1FFFFFFFF, {1'b0, hoff});
    // Target above both limits; full-scale slope climbs 65 per control cycle
    wr(`REG_MAX_TORQUE, 32'h320);
    wr(`REG_MAX_CURRENT, 32'h258);
    wr(`REG_MOTOR_MAX_CURRENT, 32'h5DC);
    wr(`REG_TORQUE_SLOPE, 32'hFFFF);
    wr(`REG_TORQUE_WINDOW, 32'h14);
    wr(`REG_TORQUE_WIN_TIME, 32'h1);
    wr(`REG_SUBMODE, 32'h0);
    wr(`REG_TARGET_TORQUE, 32'h4B0);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_MODE, {24'h0, `MODE_TORQUE});
    closed_loop_on <= 1'b1;
    actual_torque <= 16'h258;
    // One cycle to start, ten more to ramp up to the clamp
    ticks(12);
    check({17'h0, torque_demand}, 33'h258);
    check({32'h0, torque_active}, 33'h1);
    check({32'h0, speed_cap_on}, 33'h1);
    rd(`REG_STATUS, 33'hC00, 33'hC00);
    rd(`REG_TORQUE_DEMAND, 33'hFFFF, 33'h258);
    // Halt while turning, then at standstill
    wr(`REG_SUBMODE, 32'h20);
    wr(`REG_CTRL, 32'h100);
    ticks(2);
    check({17'h0, torque_demand}, 33'h1D6);
    check({32'h0, speed_cap_on}, 33'h0);
    rd(`REG_STATUS, 33'h400, 33'h0);
    ticks(8);
    check({17'h0, torque_demand}, 33'h0);
    rd(`REG_TORQUE_DEMAND, 33'hFFFF, 33'h0);
    speed_zero <= 1'b1;
    ticks(1);
    rd(`REG_STATUS, 33'h400, 33'h400);
    closed_loop_on <= 1'b0;
    ticks(1);
    check({32'h0, torque_active}, 33'h0);
    // Homing: switch search, index search, completion
    wr(`REG_CTRL, 32'h0);
    wr(`REG_MODE, {24'h0, `MODE_HOMING});
    wr(`REG_SWITCH_SPEED, 32'h12C);
    wr(`REG_ZERO_SPEED, 32'h32);
    wr(`REG_MAX_SPEED, 32'hC8);
    wr(`REG_HOMING_ACCEL, 32'h4D);
    ticks(1);
    rd(`REG_STATUS, 33'h3400, 33'h400);
    wr(`REG_CTRL, 32'h10);
    // One cycle leaves idle, the next drives the search speed
    ticks(2);
    check({1'b0, speed_command}, 33'hC8);
    check({1'b0, accel_command}, 33'h4D);
    rd(`REG_STATUS, 33'h3400, 33'h0);
    switch_found <= 1'b1;
    ticks(2);
    check({1'b0, speed_command}, 33'h32);
    @(posedge ref_clk) index_found <= 1'b1;
    n = 0;
    while (position_zero_load !== 1'b1 && n < 3 * `CYCLE_COUNT) begin
      @(negedge ref_clk);
      n++;
    end
    check({32'h0, position_zero_load}, 33'h1);
    if (n >= 3 * `CYCLE_COUNT) tally_and_finish();
    repeat (2) @(negedge ref_clk);
    check({1'b0, position_zero}, {1'b0, hoff});
    ticks(1);
    rd(`REG_STATUS, 33'h3400, 33'h1400);
    // A later run clears the homed flag and an error keeps it clear
    wr(`REG_CTRL, 32'h0);
    switch_found <= 1'b0;
    index_found <= 1'b0;
    ticks(1);
    wr(`REG_CTRL, 32'h10);
    ticks(2);
    rd(`REG_STATUS, 33'h3400, 33'h0);
    homing_fault <= 1'b1;
    ticks(2);
    rd(`REG_STATUS, 33'h3400, 33'h2400);
    // Block run: detect, push for two cycles, then complete
    homing_fault <= 1'b0;
    block_homing <= 1'b1;
    motor_current <= 16'h0200;
    wr(`REG_CTRL, 32'h0);
    wr(`REG_BLOCK_CURRENT, 32'h100);
    wr(`REG_BLOCK_TIME, 32'h2);
    ticks(1);
    wr(`REG_CTRL, 32'h10);
    ticks(5);
    rd(`REG_STATUS, 33'h3400, 33'h0);
    ticks(1);
    rd(`REG_STATUS, 33'h3400, 33'h1400);
    tally_and_finish();
  end
endmodule // torque_and_homing_mode_ctrl_tb_top

// ===== rtl/torque_and_homing_mode_ctrl.v
// Profile torque and homing mode control with APB registers
// Behaviour
// - Torque mode runs only while closed-loop control is enabled.
// - Halt bit 8 holds motor; falling edge starts, rising edge ramps to standstill.
// - Status bit 10 with halt bit encodes reached, braking, standstill.
// - Torque reached only after staying inside window for window time.
// - Status bit 11 set while target torque exceeds maximum torque.
// - Torque values are thousandths of rated torque, equal to rated current.
// - Target clamped to smaller of maximum torque and maximum current.
// - Ramp output published as demand, slope limited per second.
// - Above rated only with overload duration set; always capped by motor maximum.
// - Submode bit 5 picks speed-capped velocity control or pure torque.
// - Homing runs while controlword bit 4 is one until reference reached.
// - Status bits 13,12,10 encode homing progress and errors.
// - Bit 12 set after full homing; cleared during later runs and on error.
// - On completion position zero is placed at home offset.
// - Switch search speed, then index search speed, both capped at maximum.
// - Homing acceleration used for start and braking.
// - Block seen above current threshold, then drive on for set milliseconds.
`timescale 1ns/100ps
`include "torque_homing_defs.vh"
module torque_and_homing_mode_ctrl (
  input wire ref_clk,
  input wire rst_b,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire closed_loop_on,
  input wire [15:0] actual_torque,
  input wire [15:0] motor_current,
  input wire speed_zero,
  input wire switch_found,
  input wire index_found,
  input wire block_homing,
  input wire homing_fault,
  output reg [15:0] torque_demand,
  output reg torque_active,
  output reg speed_cap_on,
  output reg [31:0] speed_command,
  output reg [31:0] accel_command,
  output reg [31:0] position_zero,
  output reg position_zero_load
);
  // Homing states
  localparam H_IDLE = 3'd0;
  localparam H_SWITCH = 3'd1;
  localparam H_INDEX = 3'd2;
  localparam H_BLOCK = 3'd3;
  localparam H_DONE = 3'd4;
  localparam H_ERROR = 3'd5;
  reg rst_s1, rst_n;
  reg [7:0] mode;
  reg [15:0] ctrl;
  reg [15:0] status;
  reg [15:0] target_torque, max_torque, max_current, motor_max_current, torque_slope;
  reg [15:0] torque_window, torque_win_time, overload_time, submode;
  reg [31:0] home_offset, switch_speed, zero_speed, max_speed, homing_accel;
  reg [15:0] block_current, block_time;
  reg [17:0] div_count;
  reg tick;
  reg halt_prev;
  reg running;
  reg [2:0] hstate;
  reg homed;
  reg [15:0] block_count;
  reg [15:0] limit_a, limit_b, limit, clamped, step_now;
  reg [16:0] diff;
  reg in_window;
  wire win_done;
  wire torque_mode = (mode == `MODE_TORQUE) && closed_loop_on;
  wire homing_mode = (mode == `MODE_HOMING);
  wire halt = ctrl[`CW_HALT];
  wire wr = psel && penable && pwrite;
  // Reset released through two flops
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end
  // Control cycle tick divider
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= 18'h00000;
      tick <= 1'b0;
    end else if (div_count == `CYCLE_COUNT - 1) begin
      div_count <= 18'h00000;
      tick <= 1'b1;
    end else begin
      div_count <= div_count + 18'h00001;
      tick <= 1'b0;
    end
  end
  // Zero-wait APB slave, unmapped addresses error
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr > `REG_HOMING_OUT || paddr[1:0] != 2'b00);
  // Register writes
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= 8'h00;
      ctrl <= 16'h0000;
      target_torque <= 16'h0000;
      max_torque <= `PERMILLE_FULL;
      max_current <= `PERMILLE_FULL;
      motor_max_current <= `PERMILLE_FULL;
      torque_slope <= `PERMILLE_FULL;
      torque_window <= 16'h0000;
      torque_win_time <= 16'h0000;
      overload_time <= 16'h0000;
      submode <= 16'h0000;
      home_offset <= 32'h00000000;
      switch_speed <= 32'h00000000;
      zero_speed <= 32'h00000000;
      max_speed <= 32'hFFFFFFFF;
      homing_accel <= 32'h00000000;
      block_current <= 16'hFFFF;
      block_time <= 16'h0000;
    end else if (wr && !pslverr) begin
      case (paddr)
        `REG_MODE: mode <= pwdata[7:0];
        `REG_CTRL: ctrl <= pwdata[15:0];
        `REG_TARGET_TORQUE: target_torque <= pwdata[15:0];
        `REG_MAX_TORQUE: max_torque <= pwdata[15:0];
        `REG_MAX_CURRENT: max_current <= pwdata[15:0];
        `REG_MOTOR_MAX_CURRENT: motor_max_current <= pwdata[15:0];
        `REG_TORQUE_SLOPE: torque_slope <= pwdata[15:0];
        `REG_TORQUE_WINDOW: torque_window <= pwdata[15:0];
        `REG_TORQUE_WIN_TIME: torque_win_time <= pwdata[15:0];
        `REG_OVERLOAD_TIME: overload_time <= pwdata[15:0];
        `REG_SUBMODE: submode <= pwdata[15:0];
        `REG_HOME_OFFSET: home_offset <= pwdata;
        `REG_SWITCH_SPEED: switch_speed <= pwdata;
        `REG_ZERO_SPEED: zero_speed <= pwdata;
        `REG_MAX_SPEED: max_speed <= pwdata;
        `REG_HOMING_ACCEL: homing_accel <= pwdata;
        `REG_BLOCK_CURRENT: block_current <= pwdata[15:0];
        `REG_BLOCK_TIME: block_time <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // Read mux
  always @* begin
    case (paddr)
      `REG_MODE: prdata = {24'h000000, mode};
      `REG_CTRL: prdata = {16'h0000, ctrl};
      `REG_STATUS: prdata = {16'h0000, status};
      `REG_TARGET_TORQUE: prdata = {16'h0000, target_torque};
      `REG_MAX_TORQUE: prdata = {16'h0000, max_torque};
      `REG_MAX_CURRENT: prdata = {16'h0000, max_current};
      `REG_MOTOR_MAX_CURRENT: prdata = {16'h0000, motor_max_current};
      `REG_TORQUE_SLOPE: prdata = {16'h0000, torque_slope};
      `REG_TORQUE_WINDOW: prdata = {16'h0000, torque_window};
      `REG_TORQUE_WIN_TIME: prdata = {16'h0000, torque_win_time};
      `REG_OVERLOAD_TIME: prdata = {16'h0000, overload_time};
      `REG_SUBMODE: prdata = {16'h0000, submode};
      `REG_TORQUE_ACTUAL: prdata = {16'h0000, actual_torque};
      `REG_TORQUE_DEMAND: prdata = {16'h0000, torque_demand};
      `REG_HOME_OFFSET: prdata = home_offset;
      `REG_SWITCH_SPEED: prdata = switch_speed;
      `REG_ZERO_SPEED: prdata = zero_speed;
      `REG_MAX_SPEED: prdata = max_speed;
      `REG_HOMING_ACCEL: prdata = homing_accel;
      `REG_BLOCK_CURRENT: prdata = {16'h0000, block_current};
      `REG_BLOCK_TIME: prdata = {16'h0000, block_time};
      `REG_HOMING_OUT: prdata = {13'h0000, hstate, 15'h0000, homed};
      default: prdata = 32'h00000000;
    endcase
  end
  // Torque limit chain, all in permille of rated current
  always @* begin
    limit_a = (max_torque < max_current) ? max_torque : max_current;
    // Overdrive above rated only with an overload duration configured
    limit_b = (overload_time == 16'h0000 && limit_a > `RATED_PERMILLE) ? `RATED_PERMILLE : limit_a;
    limit = (limit_b < motor_max_current) ? limit_b : motor_max_current;
    clamped = (target_torque > limit) ? limit : target_torque;
    // Slope is per second; one step per control tick, at least one unit
    step_now = (torque_slope < `CYCLES_PER_SEC) ? 16'h0001 : torque_slope / `CYCLES_PER_SEC;
    diff = (actual_torque > clamped) ? {1'b0, actual_torque - clamped} : {1'b0, clamped - actual_torque};
    in_window = torque_mode && running && !halt && (diff <= {1'b0, torque_window});
  end
  window_timer u_window (
    .clk(ref_clk),
    .rst_n(rst_n),
    .tick(tick),
    .cond(in_window),
    .limit(torque_win_time),
    .done(win_done)
  );
  // Torque ramp and halt handling, one step per control tick
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      torque_demand <= 16'h0000;
      halt_prev <= 1'b1;
      running <= 1'b0;
      torque_active <= 1'b0;
      speed_cap_on <= 1'b1;
    end else if (tick) begin
      halt_prev <= halt;
      torque_active <= torque_mode;
      speed_cap_on <= !submode[`SUBMODE_REAL_TORQUE];
      if (!torque_mode) begin
        running <= 1'b0;
        torque_demand <= 16'h0000;
      end else begin
        if (halt_prev && !halt) begin
          running <= 1'b1;
        end else if (!halt_prev && halt) begin
          running <= 1'b0;
        end
        // Halted axis ramps demand down to zero under the same slope
        if (halt || !running) begin
          torque_demand <= (torque_demand > step_now) ? torque_demand - step_now : 16'h0000;
        end else if (torque_demand + step_now < clamped) begin
          torque_demand <= torque_demand + step_now;
        end else if (torque_demand > clamped + step_now) begin
          torque_demand <= torque_demand - step_now;
        end else begin
          torque_demand <= clamped;
        end
      end
    end
  end
  // Homing sequencer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hstate <= H_IDLE;
      homed <= 1'b0;
      block_count <= 16'h0000;
      speed_command <= 32'h00000000;
      accel_command <= 32'h00000000;
      position_zero <= 32'h00000000;
      position_zero_load <= 1'b0;
    end else begin
      position_zero_load <= 1'b0;
      if (tick) begin
        accel_command <= homing_accel;
        case (hstate)
          H_IDLE: begin
            speed_command <= 32'h00000000;
            if (homing_mode && ctrl[`CW_HOMING_START]) begin
              hstate <= H_SWITCH;
              homed <= 1'b0;
            end
          end
          H_SWITCH: begin
            speed_command <= (switch_speed > max_speed) ? max_speed : switch_speed;
            if (block_homing && motor_current > block_current) begin
              hstate <= H_BLOCK;
              block_count <= 16'h0000;
            end else if (switch_found) begin
              hstate <= H_INDEX;
            end
          end
          H_INDEX: begin
            speed_command <= (zero_speed > max_speed) ? max_speed : zero_speed;
            if (index_found) begin
              hstate <= H_DONE;
            end
          end
          H_BLOCK: begin
            // Keep pushing against the block for the set time
            if (block_count >= block_time) begin
              hstate <= H_DONE;
            end else begin
              block_count <= block_count + 16'h0001;
            end
          end
          H_DONE: begin
            speed_command <= 32'h00000000;
          end
          H_ERROR: begin
            speed_command <= 32'h00000000;
          end
          default: hstate <= H_IDLE;
        endcase
        if (hstate == H_INDEX && index_found || hstate == H_BLOCK && block_count >= block_time) begin
          homed <= 1'b1;
          position_zero <= home_offset;
          position_zero_load <= 1'b1;
        end
        // Master abort or fault ends the run
        if (hstate == H_SWITCH || hstate == H_INDEX || hstate == H_BLOCK) begin
          if (homing_fault) begin
            hstate <= H_ERROR;
            homed <= 1'b0;
          end else if (!ctrl[`CW_HOMING_START] || !homing_mode) begin
            hstate <= H_IDLE;
          end
        end else if ((hstate == H_DONE || hstate == H_ERROR) && !ctrl[`CW_HOMING_START]) begin
          hstate <= H_IDLE;
        end
      end
    end
  end
  // Statusword refreshed once per control tick
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 16'h0000;
    end else if (tick) begin
      status <= 16'h0000;
      if (torque_mode) begin
        status[`SW_TARGET_REACHED] <= halt ? speed_zero : win_done;
        status[`SW_LIMIT] <= target_torque > max_torque;
      end else if (homing_mode) begin
        // Bits 13,12,10
        status[`SW_HOMING_ERROR] <= (hstate == H_ERROR);
        status[`SW_HOMED] <= homed && hstate != H_ERROR;
        status[`SW_TARGET_REACHED] <= (hstate == H_ERROR) ? speed_zero :
          (hstate == H_DONE || hstate == H_IDLE);
      end
    end
  end
endmodule // torque_and_homing_mode_ctrl

// ===== rtl/torque_homing_defs.vh
// Register map, field positions and timing constants for the torque and homing mode controller
`ifndef TORQUE_HOMING_DEFS_VH
`define TORQUE_HOMING_DEFS_VH
// Register byte offsets
`define REG_MODE 12'h000
`define REG_CTRL 12'h004
`define REG_STATUS 12'h008
`define REG_TARGET_TORQUE 12'h00C
`define REG_MAX_TORQUE 12'h010
`define REG_MAX_CURRENT 12'h014
`define REG_MOTOR_MAX_CURRENT 12'h018
`define REG_TORQUE_SLOPE 12'h01C
`define REG_TORQUE_WINDOW 12'h020
`define REG_TORQUE_WIN_TIME 12'h024
`define REG_OVERLOAD_TIME 12'h028
`define REG_SUBMODE 12'h02C
`define REG_TORQUE_ACTUAL 12'h030
`define REG_TORQUE_DEMAND 12'h034
`define REG_HOME_OFFSET 12'h038
`define REG_SWITCH_SPEED 12'h03C
`define REG_ZERO_SPEED 12'h040
`define REG_MAX_SPEED 12'h044
`define REG_HOMING_ACCEL 12'h048
`define REG_BLOCK_CURRENT 12'h04C
`define REG_BLOCK_TIME 12'h050
`define REG_HOMING_OUT 12'h054
// Mode selector values
`define MODE_TORQUE 8'h04
`define MODE_HOMING 8'h06
// Controlword, statusword and submode bits
`define CW_HOMING_START 4
`define CW_HALT 8
`define SW_TARGET_REACHED 10
`define SW_LIMIT 11
`define SW_HOMED 12
`define SW_HOMING_ERROR 13
`define SUBMODE_REAL_TORQUE 5
// Torque unit: thousandths of rated current
`define PERMILLE_FULL 16'h03E8
`define RATED_PERMILLE 16'h03E8
// Control cycle length in clocks; one cycle stands for a millisecond of drive time
// Limitation: a true 1 ms cycle would need 200000 clocks here
`define CYCLE_COUNT 18'h003E8
// Control cycles per second, sized to the 16-bit slope register
`define CYCLES_PER_SEC 16'h03E8
`endif

// ===== rtl/window_timer.v
// Dwell timer: counts control ticks a condition has held
`timescale 1ns/100ps
module window_timer (
  input wire clk,
  input wire rst_n,
  input wire tick,
  input wire cond,
  input wire [15:0] limit,
  output reg done
);
  reg [15:0] count;
  // Restart whenever the condition drops out
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      done <= 1'b0;
    end else if (!cond) begin
      count <= 16'h0000;
      done <= 1'b0;
    end else if (tick) begin
      if (count >= limit) begin
        done <= 1'b1;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end
endmodule // window_timer
